/* File: hw/psx_pkg.sv */
// shared constants and carriers for the store, barrier and trap executor
package psx_pkg;
    // primary opcodes
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_REG_IMMEDIATE_GROUP = 6'h01;
    localparam logic [5:0] OP_SYSTEM_COPROC_GROUP = 6'h10;
    localparam logic [5:0] OP_SWR = 6'h2e;
    localparam logic [5:0] OP_LL = 6'h30;
    localparam logic [5:0] OP_SC = 6'h38;
    // special-group function codes
    localparam logic [5:0] F_SYSTEM_CALL_INSN = 6'h0c;
    localparam logic [5:0] F_SYNC = 6'h0f;
    localparam logic [5:0] F_TGE = 6'h30;
    localparam logic [5:0] F_TRAP_GE_UNSIGNED_REG = 6'h31;
    localparam logic [5:0] F_TEQ = 6'h34;
    // system coprocessor group function codes
    localparam logic [5:0] F_XPROBE = 6'h08;
    localparam logic [5:0] F_XREAD = 6'h01;
    // register-immediate group selectors
    localparam logic [4:0] RI_TRAP_GE_SIGNED_IMM = 5'h08;
    localparam logic [4:0] RI_TRAP_GE_UNSIGNED_IMM = 5'h09;
    localparam logic [4:0] RI_TRAP_EQUAL_IMM = 5'h0c;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0c;
    // control fields
    localparam int CTL_CORE_BE = 0;
    localparam int CTL_MEM_BE = 1;
    localparam int CTL_FLIP = 2;
    localparam int CTL_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // event fields of status and mask
    localparam int EV_SYSTEM_CALL_INSN = 0;
    localparam int EV_TRAP = 1;
    localparam int EV_BUS = 2;
    localparam int EV_ADDR = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    // state register field position
    localparam int ST_CNT_LSB = 8;
    // highest byte index in a word
    localparam logic [1:0] LANE_TOP = 2'h3;

    typedef enum logic [1:0] {
        EXC_SYS = 2'b00,
        EXC_TRAP = 2'b01,
        EXC_BUS = 2'b10,
        EXC_ADDR = 2'b11
    } exc_e;

    typedef struct packed {
        logic [31:0] word;
        logic [31:0] rs_val;
        logic [31:0] rt_val;
        logic user;
    } insn_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] be;
        logic [1:0] acc_type;
    } st_req_s;
endpackage

/* File: hw/swr_lane_gen.sv */
// byte lanes, access type and memory offset of a right-part store
`timescale 1ns/1ps
module swr_lane_gen
    import psx_pkg::*;
(
    // address and data
    input wire logic [31:0] va_i,
    input wire logic [31:0] rt_i,
    // endian settings
    input wire logic core_be_i,
    input wire logic mem_be_i,
    // formed request
    output st_req_s req_o
);
    logic [1:0] byte_idx;
    logic [2:0] off;

    always_comb
    begin
        // lane index counted from the least significant lane
        byte_idx = va_i[1:0] ^ {2{core_be_i}};
        if (mem_be_i)
        begin
            off = {va_i[2] ^ ~core_be_i, 2'b00};
        end
        else
        begin
            off = va_i[2:0] ^ {3{core_be_i}};
        end
        req_o.addr = {va_i[31:3], off};
        req_o.data = rt_i << {byte_idx, 3'b000};
        req_o.be = 4'hf << byte_idx;
        req_o.acc_type = core_be_i ? va_i[1:0] : LANE_TOP - va_i[1:0];
    end
endmodule

/* File: hw/psx_exec.sv */
// executor for right-part store, barrier, system call and trap instructions
`timescale 1ns/1ps
// Functional notes
// - store address is base register plus sign-extended 16-bit displacement
// - store writes one to four bytes from the register's low byte upward
// - store never raises an alignment address exception
// - access type is 3 minus low bits little-endian, low bits big-endian
// - memory offset follows memory and core endian settings
// - barrier holds later loads and stores until earlier ones complete
// - barrier may be a no-operation on strictly ordered implementations
// - load-linked and store-conditional order memory like a barrier
// - barrier runs in user mode without privilege exception
// - system call always raises a system call exception; a store fault in the same cycle takes the exception code instead
// - code field of system call and register traps is ignored
// - register-equal trap fires when both sources are equal
// - immediate-equal trap compares against the sign-extended immediate
// - register greater-or-equal trap compares signed
// - immediate greater-or-equal trap compares signed with extended immediate
// - unsigned greater-or-equal traps compare unsigned, immediate still sign-extended
// - translation probe and read opcodes need not raise exceptions
// - store can report bus error and address error from its access
module psx_exec
    import psx_pkg::*;
#(
    parameter int CNT_W = 4,
    parameter bit IN_ORDER = 1'b0
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // instruction from decode
    input wire logic insn_valid_i,
    input wire insn_s insn_i,
    output logic insn_ready_o,
    // other loads and stores in flight
    input wire logic lsu_busy_i,
    // store request to memory stage
    output logic st_valid_o,
    input wire logic st_ready_i,
    output st_req_s st_req_o,
    // store completion
    input wire logic st_done_i,
    input wire logic st_bus_err_i,
    input wire logic st_addr_err_i,
    // exception unit
    output logic exc_valid_o,
    output exc_e exc_code_o,
    output logic flush_o,
    // interrupt
    output logic irq_o
);
    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_SEND = 1'b1
    } state_e;

    logic rst_meta_q;
    logic rst_sync_b;
    state_e state_q;
    st_req_s st_q;
    st_req_s lane_req;
    logic [CNT_W-1:0] cnt_q;
    logic [CTL_W-1:0] ctrl_q;
    logic [EV_W-1:0] status_q;
    logic [EV_W-1:0] mask_q;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] clr;
    logic exc_valid_q;
    exc_e exc_code_q;
    logic [31:0] rdata_q;

    logic [5:0] op;
    logic [5:0] fn;
    logic [4:0] ri_sel;
    logic [31:0] imm_sx;
    logic [31:0] va;
    logic [31:0] opb;
    logic is_swr;
    logic is_sync;
    logic is_llsc;
    logic is_sys;
    logic is_eq;
    logic is_ges;
    logic is_geu;
    logic is_trap;
    logic is_xlate;
    logic trap_cond;
    logic needs_drain;
    logic drained;
    logic take;
    logic take_swr;
    logic core_be;
    logic st_fire;
    logic mem_err;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_b <= rst_meta_q;
        end
    end

    // decode; code field bits 15:6 are deliberately never read
    always_comb
    begin
        op = insn_i.word[31:26];
        fn = insn_i.word[5:0];
        ri_sel = insn_i.word[20:16];
        imm_sx = {{16{insn_i.word[15]}}, insn_i.word[15:0]};
        va = insn_i.rs_val + imm_sx;
        is_swr = op == OP_SWR;
        is_sync = (op == OP_SPECIAL) && (fn == F_SYNC);
        is_llsc = (op == OP_LL) || (op == OP_SC);
        is_sys = (op == OP_SPECIAL) && (fn == F_SYSTEM_CALL_INSN);
        is_eq = ((op == OP_SPECIAL) && (fn == F_TEQ))
            || ((op == OP_REG_IMMEDIATE_GROUP) && (ri_sel == RI_TRAP_EQUAL_IMM));
        is_ges = ((op == OP_SPECIAL) && (fn == F_TGE))
            || ((op == OP_REG_IMMEDIATE_GROUP) && (ri_sel == RI_TRAP_GE_SIGNED_IMM));
        is_geu = ((op == OP_SPECIAL) && (fn == F_TRAP_GE_UNSIGNED_REG))
            || ((op == OP_REG_IMMEDIATE_GROUP) && (ri_sel == RI_TRAP_GE_UNSIGNED_IMM));
        is_trap = is_eq || is_ges || is_geu;
        // unsupported probe and read just retire quietly
        is_xlate = (op == OP_SYSTEM_COPROC_GROUP) && insn_i.word[25]
            && ((fn == F_XPROBE) || (fn == F_XREAD));
        opb = (op == OP_REG_IMMEDIATE_GROUP) ? imm_sx : insn_i.rt_val;
        trap_cond = (is_eq && (insn_i.rs_val == opb))
            || (is_ges && ($signed(insn_i.rs_val) >= $signed(opb)))
            || (is_geu && (insn_i.rs_val >= opb));
    end

    // barrier and linked pair wait for the memory side to drain
    assign core_be = ctrl_q[CTL_CORE_BE] ^ (insn_i.user & ctrl_q[CTL_FLIP]);
    assign needs_drain = !IN_ORDER && (is_sync || is_llsc);
    assign drained = (cnt_q == '0) && !lsu_busy_i;
    // no privilege check on the barrier at all
    assign insn_ready_o = (state_q == S_IDLE)
        && (!needs_drain || drained);
    assign take = insn_valid_i && insn_ready_o;
    assign take_swr = take && is_swr;
    assign st_fire = st_valid_o && st_ready_i;
    assign mem_err = st_bus_err_i || st_addr_err_i;

    swr_lane_gen u_lanes (
        .va_i(va),
        .rt_i(insn_i.rt_val),
        .core_be_i(core_be),
        .mem_be_i(ctrl_q[CTL_MEM_BE]),
        .req_o(lane_req)
    );

    // store sequencing
    always_ff @(posedge clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state_q <= S_IDLE;
            st_q <= '0;
        end
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    if (take_swr)
                    begin
                        st_q <= lane_req;
                        state_q <= S_SEND;
                    end
                end
                S_SEND:
                begin
                    if (st_ready_i)
                    begin
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    assign st_valid_o = state_q == S_SEND;
    assign st_req_o = st_q;

    // stores handed over but not yet completed
    always_ff @(posedge clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cnt_q <= '0;
        end
        else if (st_fire && !st_done_i)
        begin
            cnt_q <= cnt_q + 1'b1;
        end
        else if (!st_fire && st_done_i && (cnt_q != '0))
        begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // events; alignment never adds an address error here
    always_comb
    begin
        ev_set = '0;
        ev_set[EV_SYSTEM_CALL_INSN] = take && is_sys;
        ev_set[EV_TRAP] = take && trap_cond;
        ev_set[EV_BUS] = st_bus_err_i;
        ev_set[EV_ADDR] = st_addr_err_i;
        clr = (wr_i && (addr_i == REG_STATUS)) ? wdata_i[EV_W-1:0] : '0;
    end

    // exception to the unit; flush stops younger commits
    always_ff @(posedge clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            exc_valid_q <= 1'b0;
            exc_code_q <= EXC_SYS;
        end
        else
        begin
            exc_valid_q <= |ev_set;
            // older store faults outrank the instruction now retiring
            if (st_addr_err_i)
            begin
                exc_code_q <= EXC_ADDR;
            end
            else if (st_bus_err_i)
            begin
                exc_code_q <= EXC_BUS;
            end
            else if (ev_set[EV_SYSTEM_CALL_INSN])
            begin
                exc_code_q <= EXC_SYS;
            end
            else if (ev_set[EV_TRAP])
            begin
                exc_code_q <= EXC_TRAP;
            end
        end
    end

    assign exc_valid_o = exc_valid_q;
    assign exc_code_o = exc_code_q;
    assign flush_o = exc_valid_q;

    // sticky status, set beats write-one clear
    always_ff @(posedge clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            status_q <= STATUS_RST;
        end
        else
        begin
            status_q <= (status_q & ~clr) | ev_set;
        end
    end

    // control and mask writes
    always_ff @(posedge clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ctrl_q <= CTRL_RST;
            mask_q <= MASK_RST;
        end
        else if (wr_i)
        begin
            if (addr_i == REG_CTRL)
            begin
                ctrl_q <= wdata_i[CTL_W-1:0];
            end
            if (addr_i == REG_MASK)
            begin
                mask_q <= wdata_i[EV_W-1:0];
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            rdata_q <= '0;
        end
        else if (rd_i)
        begin
            rdata_q <= '0;
            unique case (addr_i)
                REG_CTRL: rdata_q[CTL_W-1:0] <= ctrl_q;
                REG_STATUS: rdata_q[EV_W-1:0] <= status_q;
                REG_MASK: rdata_q[EV_W-1:0] <= mask_q;
                REG_STATE:
                begin
                    rdata_q[0] <= insn_valid_i && needs_drain && !drained;
                    rdata_q[1] <= state_q == S_SEND;
                    rdata_q[ST_CNT_LSB +: CNT_W] <= cnt_q;
                end
                default: rdata_q <= '0;
            endcase
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = |(status_q & mask_q);

    // checks
    property p_swr_addr;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take_swr |=> st_req_o.addr[31:3] == $past(va[31:3]) && st_valid_o;
    endproperty
    a_swr_addr: assert property (p_swr_addr) else $error("store address wrong");

    property p_swr_lanes;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take_swr |=> st_req_o.be[3]
            && ($countones(st_req_o.be)
                == ($past(core_be) ? 1 + $past(va[1:0]) : 4 - $past(va[1:0])));
    endproperty
    a_swr_lanes: assert property (p_swr_lanes) else $error("store lanes wrong");

    property p_swr_type;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take_swr |=> st_req_o.acc_type
            == ($past(core_be) ? $past(va[1:0]) : LANE_TOP - $past(va[1:0]));
    endproperty
    a_swr_type: assert property (p_swr_type) else $error("access type wrong");

    property p_swr_off;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take_swr && !ctrl_q[CTL_MEM_BE] |=> st_req_o.addr[2:0]
            == ($past(core_be) ? 3'd7 - $past(va[2:0]) : $past(va[2:0]));
    endproperty
    a_swr_off: assert property (p_swr_off) else $error("memory offset wrong");

    property p_no_align;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take_swr && !mem_err |=> !exc_valid_o;
    endproperty
    a_no_align: assert property (p_no_align) else $error("alignment fault raised");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_sync_b)
        insn_valid_i && is_sync && !IN_ORDER && (cnt_q != '0) |-> !insn_ready_o;
    endproperty
    a_hold: assert property (p_hold) else $error("barrier passed early");

    property p_system_call_insn;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take && is_sys |=> exc_valid_o && status_q[EV_SYSTEM_CALL_INSN];
    endproperty
    a_system_call_insn: assert property (p_system_call_insn) else $error("system call lost");

    property p_trap_true;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take && is_trap && trap_cond && !mem_err |=> flush_o && exc_code_o == EXC_TRAP;
    endproperty
    a_trap_true: assert property (p_trap_true) else $error("trap not raised");

    property p_trap_false;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take && (is_trap || is_sync) && !trap_cond && !mem_err |=> !exc_valid_o;
    endproperty
    a_trap_false: assert property (p_trap_false) else $error("spurious exception");

    property p_xlate_quiet;
        @(posedge clk_i) disable iff (!rst_sync_b)
        take && is_xlate && !mem_err |=> !exc_valid_o;
    endproperty
    a_xlate_quiet: assert property (p_xlate_quiet) else $error("xlate op trapped");

    property p_store_err;
        @(posedge clk_i) disable iff (!rst_sync_b)
        st_bus_err_i |=> exc_valid_o && status_q[EV_BUS];
    endproperty
    a_store_err: assert property (p_store_err) else $error("bus error lost");
endmodule

/* File: bench/mem_stage_model.sv */
// memory access stage model that accepts, completes and faults stores
`timescale 1ns/1ps
module mem_stage_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // store handshake
    input wire logic st_valid_i,
    output logic st_ready_o,
    // completion; fault_sel_i 1 gives a bus error, 2 an address error
    input wire logic [1:0] fault_sel_i,
    output logic st_done_o,
    output logic st_bus_err_o,
    output logic st_addr_err_o
);
    integer pseed = 17790;
    logic [1:0] stall_q;
    logic [1:0] pend_q;

    // random stall keeps both prompt and slow hand-overs in play
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_ready_o <= 1'b0;
            stall_q <= 2'h0;
            pend_q <= 2'h0;
            st_done_o <= 1'b0;
            st_bus_err_o <= 1'b0;
            st_addr_err_o <= 1'b0;
        end
        else
        begin
            st_done_o <= 1'b0;
            st_bus_err_o <= 1'b0;
            st_addr_err_o <= 1'b0;
            if (st_valid_i && st_ready_o)
            begin
                st_ready_o <= 1'b0;
                pend_q <= 2'h2;
            end
            else if (st_valid_i && stall_q == 2'h0)
                st_ready_o <= 1'b1;
            else if (st_valid_i)
                stall_q <= stall_q - 2'h1;
            else
                stall_q <= 2'($unsigned($random(pseed)) % 3);
            if (pend_q == 2'h1)
            begin
                st_done_o <= 1'b1;
                st_bus_err_o <= (fault_sel_i == 2'h1);
                st_addr_err_o <= (fault_sel_i == 2'h2);
            end
            if (pend_q != 2'h0)
                pend_q <= pend_q - 2'h1;
        end
    end
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the store, barrier and trap executor
`timescale 1ns/1ps
module testbench;
    import psx_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic insn_valid_i = 1'b0;
    insn_s insn_i = '0;
    logic lsu_busy_i = 1'b0;
    logic [1:0] fault_sel = 2'h0;
    logic [31:0] rdata_o;
    logic insn_ready_o, st_valid_o, st_ready_i, st_done_i, st_bus_err_i, st_addr_err_i;
    logic exc_valid_o, flush_o, irq_o;
    st_req_s st_req_o;
    exc_e exc_code_o;
    int err_total = 0;
    int cmp_count = 0;
    integer seed = 17790;
    st_req_s st_q[$];
    exc_e exc_q[$];

    always #5 clk_i = ~clk_i;

    psx_exec u_psx_exec (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .insn_valid_i(insn_valid_i),
        .insn_i(insn_i), .insn_ready_o(insn_ready_o), .lsu_busy_i(lsu_busy_i),
        .st_valid_o(st_valid_o), .st_ready_i(st_ready_i), .st_req_o(st_req_o),
        .st_done_i(st_done_i), .st_bus_err_i(st_bus_err_i), .st_addr_err_i(st_addr_err_i),
        .exc_valid_o(exc_valid_o), .exc_code_o(exc_code_o), .flush_o(flush_o), .irq_o(irq_o));

    mem_stage_model u_mem_stage_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .st_valid_i(st_valid_o), .st_ready_o(st_ready_i), .fault_sel_i(fault_sel),
        .st_done_o(st_done_i), .st_bus_err_o(st_bus_err_i), .st_addr_err_o(st_addr_err_i));

    function automatic logic [31:0] rnd();
        rnd = $random(seed);
    endfunction

    function automatic st_req_s exp_st(logic [31:0] va, logic [31:0] rt, logic cbe, logic mbe);
        logic [1:0] b;
        logic [2:0] off;
        // addressed lane, counted from the least significant lane
        b = cbe ? LANE_TOP - va[1:0] : va[1:0];
        if (mbe)
            off = (va[2] ^ cbe) ? 3'h0 : 3'h4;
        else
            off = cbe ? 3'h7 - va[2:0] : va[2:0];
        exp_st.addr = {va[31:3], off};
        exp_st.data = rt << (8 * b);
        exp_st.be = 4'hf << b;
        exp_st.acc_type = cbe ? va[1:0] : LANE_TOP - va[1:0];
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        chk(rdata_o, e);
    endtask

    task automatic issue(input logic [31:0] w, input logic [31:0] rs, input logic [31:0] rt,
        input logic u);
        int n;
        n = 0;
        @(posedge clk_i);
        insn_valid_i <= 1'b1;
        insn_i <= '{word: w, rs_val: rs, rt_val: rt, user: u};
        @(posedge clk_i);
        while (insn_ready_o !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 200)
            err_total++;
        insn_valid_i <= 1'b0;
    endtask

    // barrier-like instruction must wait while other accesses are in flight
    task automatic held(input logic [31:0] w);
        lsu_busy_i <= 1'b1;
        fork
            issue(w, rnd(), rnd(), 1'b1);
            begin
                repeat (6) @(posedge clk_i);
                chk(insn_ready_o, 1'b0);
                lsu_busy_i <= 1'b0;
            end
        join
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        if (exc_valid_o === 1'b1)
        begin
            chk(flush_o, 1'b1);
            if (exc_q.size() == 0)
                chk(exc_valid_o, 1'b0);
            else
                chk(exc_code_o, exc_q.pop_front());
        end
        if (st_valid_o === 1'b1 && st_ready_i === 1'b1)
        begin
            if (st_q.size() == 0)
                chk(st_valid_o, 1'b0);
            else
                chk(st_req_o, st_q.pop_front());
        end
    end

    initial
    begin
        #200000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        logic [31:0] va, rs, rt, imm, se, w;
        logic [9:0] code;
        logic u, hit;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rchk(REG_CTRL, 32'h0);
        rchk(REG_STATUS, 32'h0);
        rchk(REG_MASK, 32'h0);
        rchk(8'h40, 32'h0);
        rchk(REG_STATE, 32'h0);
        reg_wr(REG_MASK, 32'hffff_ffff);
        rchk(REG_MASK, 32'hf);
        reg_wr(REG_MASK, 32'h0);
        $display("register test done");
        for (int k = 0; k < 8; k++)
        begin
            reg_wr(REG_CTRL, 32'(k));
            rchk(REG_CTRL, 32'(k));
            for (int j = 0; j < 8; j++)
            begin
                u = rnd() > 32'h8000_0000;
                imm = rnd();
                va = (rnd() & 32'hffff_fff8) | 32'(j);
                rs = va - {{16{imm[15]}}, imm[15:0]};
                rt = rnd();
                st_q.push_back(exp_st(va, rt, k[0] ^ (u & k[2]), k[1]));
                issue({OP_SWR, 5'h1, 5'h2, imm[15:0]}, rs, rt, u);
            end
        end
        reg_wr(REG_CTRL, 32'h0);
        $display("store lane test done");
        for (int t = 0; t < 6; t++)
            for (int n = 0; n < 4; n++)
            begin
                rs = rnd();
                imm = rnd();
                code = 10'(rnd());
                se = {{16{imm[15]}}, imm[15:0]};
                rt = n[0] ? rnd() : rs;
                if (t[0] && !n[0])
                    rs = se;
                case (t)
                    0: hit = (rs == rt);
                    1: hit = (rs == se);
                    2: hit = ($signed(rs) >= $signed(rt));
                    3: hit = ($signed(rs) >= $signed(se));
                    4: hit = (rs >= rt);
                    default: hit = (rs >= se);
                endcase
                case (t)
                    0: w = {OP_SPECIAL, 5'h1, 5'h2, code, F_TEQ};
                    1: w = {OP_REG_IMMEDIATE_GROUP, 5'h1, RI_TRAP_EQUAL_IMM, imm[15:0]};
                    2: w = {OP_SPECIAL, 5'h1, 5'h2, code, F_TGE};
                    3: w = {OP_REG_IMMEDIATE_GROUP, 5'h1, RI_TRAP_GE_SIGNED_IMM, imm[15:0]};
                    4: w = {OP_SPECIAL, 5'h1, 5'h2, code, F_TRAP_GE_UNSIGNED_REG};
                    default: w = {OP_REG_IMMEDIATE_GROUP, 5'h1, RI_TRAP_GE_UNSIGNED_IMM, imm[15:0]};
                endcase
                if (hit)
                    exc_q.push_back(EXC_TRAP);
                issue(w, rs, rt, rnd() > 32'h8000_0000);
            end
        exc_q.push_back(EXC_SYS);
        issue({OP_SPECIAL, 20'(rnd()), F_SYSTEM_CALL_INSN}, rnd(), rnd(), 1'b1);
        $display("trap test done");
        repeat (4) @(posedge clk_i);
        reg_wr(REG_STATUS, 32'hf);
        rchk(REG_STATUS, 32'h0);
        reg_wr(REG_MASK, 32'h2);
        exc_q.push_back(EXC_TRAP);
        issue({OP_SPECIAL, 5'h1, 5'h2, 10'h0, F_TEQ}, 32'h5, 32'h5, 1'b0);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b1);
        rchk(REG_STATUS, 32'h2);
        exc_q.push_back(EXC_SYS);
        issue({OP_SPECIAL, 20'h0, F_SYSTEM_CALL_INSN}, 32'h0, 32'h0, 1'b0);
        reg_wr(REG_STATUS, 32'h2);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        rchk(REG_STATUS, 32'h1);
        $display("interrupt test done");
        for (int f = 1; f < 3; f++)
        begin
            fault_sel <= 2'(f);
            st_q.push_back(exp_st(32'h1000_0005, 32'ha1b2_c3d4, 1'b0, 1'b0));
            exc_q.push_back(f == 1 ? EXC_BUS : EXC_ADDR);
            issue({OP_SWR, 5'h1, 5'h2, 16'h0005}, 32'h1000_0000, 32'ha1b2_c3d4, 1'b0);
            repeat (8) @(posedge clk_i);
        end
        fault_sel <= 2'h0;
        rchk(REG_STATUS, 32'hd);
        $display("store fault test done");
        st_q.push_back(exp_st(32'h1000_0005, 32'h0, 1'b0, 1'b0));
        issue({OP_SWR, 5'h1, 5'h2, 16'h0005}, 32'h1000_0000, 32'h0, 1'b0);
        issue({OP_SPECIAL, 20'h0, F_SYNC}, 32'h0, 32'h0, 1'b1);
        held({OP_SPECIAL, 20'h0, F_SYNC});
        held({OP_LL, 5'h1, 5'h2, 16'h0});
        held({OP_SC, 5'h1, 5'h2, 16'h0});
        issue({OP_SYSTEM_COPROC_GROUP, 1'b1, 19'h0, F_XPROBE}, 32'h0, 32'h0, 1'b0);
        issue({OP_SYSTEM_COPROC_GROUP, 1'b1, 19'h0, F_XREAD}, 32'h0, 32'h0, 1'b0);
        repeat (20) @(posedge clk_i);
        chk(32'(exc_q.size()), 32'h0);
        chk(32'(st_q.size()), 32'h0);
        $display("barrier test done");
        report_and_stop();
    end
endmodule
